/* hw/smbcs_flags.sv */
// SMBus control/status flags with SFR access, bus stall and engine requests.
// Assumes the SFR port and bus engine share clk_i; the clock and data pins
// arrive asynchronously and are synchronised here.
//
// Contract
// RL1: The role indicator is set by a generated START and cleared by a generated STOP or lost arbitration.
// RL2: The transmitter indicator sets on generated START or a data write before a frame, and clears on detected START, lost arbitration or no data write before a frame.
// RL3: Writing one to the begin flag requests a START, or a repeated START when already controller.
// RL4: The begin flag is set when a START plus address byte is received and only software clears it.
// RL5: Writing one to the halt flag as controller requests a STOP after the next acknowledge, and hardware clears it once that STOP is generated.
// RL6: The halt flag is set by a STOP detected while addressed as slave or by arbitration lost to a STOP.
// RL7: The acknowledge request flag sets after a received byte and clears after every acknowledge cycle.
// RL8: Arbitration is lost on an unwanted repeated START, on low clock while making STOP or repeated START, or on low data while sending one outside acknowledge bits.
// RL9: The arbitration lost flag clears whenever software clears the bus event flag; here a new loss in the same cycle keeps it set.
// RL10: The response bit reads one for an incoming low acknowledge, and a written one sends ACK while zero sends NACK.
// RL11: The bus event flag is set by START generated, arbitration lost, byte sent, byte received, address received or STOP received.
// RL12: While the bus event flag is set the clock line is held low, and only software clears the flag.
// RL13: Writing zero to the bus event flag clears it and launches the next event; writing one forces it.
// RL14: The register sits at address 0xC0 on page 0x00 and its flags are bit addressable.
// RL15: When software has not written the response bit since a received byte, a NACK is sent.
// RL16: Hardware never clears the begin flag after the requested START.
// RL17: Writes to the read-only indicator bits have no effect.
`timescale 1ns/10ps
`default_nettype none
module smbcs_flags
  import smbcs_pkg::*;
(
  input  wire logic          clk_i,         // System clock, 200 MHz
  input  wire logic          sys_rst_i,     // Asynchronous reset, active high
  input  wire logic [7:0]    sfr_addr_i,    // Byte SFR address
  input  wire logic [7:0]    sfr_page_i,    // Current SFR page
  input  wire logic          sfr_wr_i,      // Byte write strobe
  input  wire logic          sfr_rd_i,      // Byte read strobe
  input  wire logic [7:0]    sfr_wdata_i,   // Byte write data
  input  wire logic [7:0]    sfr_bit_addr_i, // Bit address
  input  wire logic          sfr_bit_wr_i,  // Bit write strobe
  input  wire logic          sfr_bit_rd_i,  // Bit read strobe
  input  wire logic          sfr_bit_val_i, // Bit write value
  input  var  smbcs_evt_type evt_i,         // Bus engine reports
  input  var  smbcs_arb_type arb_i,         // Arbitration context
  input  wire logic          scl_pin_i,     // Clock pin level, asynchronous
  input  wire logic          sda_pin_i,     // Data pin level, asynchronous
  output logic [7:0]         sfr_rdata_o,   // Read data, registered
  output logic [7:0]         ctrl_status_o, // Live register image
  output logic               start_req_o,   // START request to engine
  output logic               stop_req_o,    // STOP request to engine
  output logic               ack_out_o,     // Outgoing acknowledge, 1 = ACK
  output logic               next_event_o,  // Pulse: launch next engine step
  output logic               scl_hold_oen_o // Low = drive clock low (stall)
);
  // ==========================================================================
  // Address decode
  function automatic logic byte_hit(input logic [7:0] a, input logic [7:0] p);
    byte_hit = (a == SMBCS_SFR_ADDR) && (p == SMBCS_SFR_PAGE);
  endfunction
  function automatic logic bit_hit(input logic [7:0] a, input logic [7:0] p);
    bit_hit = (a[7:3] == SMBCS_SFR_ADDR[7:3]) && (p == SMBCS_SFR_PAGE);
  endfunction

  logic [7:0] wr_en;      // Per-bit software write enables
  logic [7:0] wr_val;     // Per-bit software write values
  logic       wr_byte;
  logic       wr_bit;

  // Byte writes and bit writes merged into per-bit enables
  always_comb begin
    wr_byte = sfr_wr_i && byte_hit(sfr_addr_i, sfr_page_i);                    // RL14
    wr_bit  = sfr_bit_wr_i && bit_hit(sfr_bit_addr_i, sfr_page_i);             // RL14
    wr_en   = 8'h00;
    wr_val  = sfr_wdata_i;
    if (wr_byte) begin
      wr_en = 8'hFF;
    end else if (wr_bit) begin
      wr_en[sfr_bit_addr_i[2:0]]  = 1'b1;
      wr_val[sfr_bit_addr_i[2:0]] = sfr_bit_val_i;
    end
  end

  // ==========================================================================
  // Pin synchronisers
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;

  // Two stages; only stage 2 is read by logic
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_pin_i};
      sda_sync_r <= {sda_sync_r[0], sda_pin_i};
    end
  end

  // ==========================================================================
  // Flags
  logic master_r, tx_ind_r, begin_r, halt_r, ackreq_r, arbl_r, ack_r, event_r;
  logic data_pend_r;  // Data register written since the last frame began
  logic ack_wr_r;     // Response bit written since the last received byte
  logic arb_lost;
  logic ev_clr;
  logic ev_set;

  // Arbitration loss sources
  always_comb begin
    arb_lost = (evt_i.rep_start_det && master_r && !begin_r)                   // RL8
             || (arb_i.gen_stop_rs && !scl_sync_r[1])                          // RL8
             || (arb_i.send_one && !arb_i.ack_bit && !sda_sync_r[1])           // RL8
             || arb_i.lost_stop;
    ev_clr   = wr_en[SMBCS_B_EVENT] && !wr_val[SMBCS_B_EVENT];                 // RL13
    ev_set   = evt_i.start_gen || arb_lost || evt_i.byte_sent                  // RL11
             || evt_i.byte_rcvd || evt_i.addr_rcvd || evt_i.stop_det;
  end

  // Role indicator; software writes ignored
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      master_r <= 1'b0;
    end else if (evt_i.start_gen) begin
      master_r <= 1'b1;                                                        // RL1
    end else if (evt_i.stop_gen || arb_lost) begin
      master_r <= 1'b0;                                                        // RL1 RL17
    end
  end

  // Transmitter indicator and pending data write
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tx_ind_r    <= 1'b0;
      data_pend_r <= 1'b0;
    end else begin
      if (evt_i.start_gen) begin
        tx_ind_r <= 1'b1;                                                      // RL2
      end else if (evt_i.start_det || arb_lost) begin
        tx_ind_r <= 1'b0;                                                      // RL2
      end else if (evt_i.frame_begin) begin
        tx_ind_r <= data_pend_r || evt_i.data_wr;                              // RL2 RL17
      end
      if (evt_i.data_wr) begin
        data_pend_r <= 1'b1;
      end else if (evt_i.frame_begin) begin
        data_pend_r <= 1'b0;
      end
    end
  end

  // Begin-condition flag and START request
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      begin_r     <= 1'b0;
      start_req_o <= 1'b0;
    end else begin
      if (evt_i.addr_rcvd) begin
        begin_r <= 1'b1;                                                       // RL4
      end else if (wr_en[SMBCS_B_BEGIN]) begin
        begin_r <= wr_val[SMBCS_B_BEGIN];                                      // RL4 RL16
      end
      if (wr_en[SMBCS_B_BEGIN] && wr_val[SMBCS_B_BEGIN]) begin
        start_req_o <= 1'b1;                                                   // RL3
      end else if (evt_i.start_gen || (wr_en[SMBCS_B_BEGIN] && !wr_val[SMBCS_B_BEGIN])) begin
        start_req_o <= 1'b0;
      end
    end
  end

  // Halt-condition flag; it doubles as the STOP request
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      halt_r <= 1'b0;
    end else if ((evt_i.stop_det && evt_i.slave_addr && !master_r) || arb_i.lost_stop) begin
      halt_r <= 1'b1;                                                          // RL6
    end else if (wr_en[SMBCS_B_HALT] && wr_val[SMBCS_B_HALT] && master_r) begin
      halt_r <= 1'b1;                                                          // RL5
    end else if (evt_i.stop_gen) begin
      halt_r <= 1'b0;                                                          // RL5
    end else if (wr_en[SMBCS_B_HALT] && !wr_val[SMBCS_B_HALT]) begin
      halt_r <= 1'b0;
    end
  end

  // Acknowledge request flag
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ackreq_r <= 1'b0;
    end else if (evt_i.byte_rcvd || evt_i.addr_rcvd) begin
      ackreq_r <= 1'b1;                                                        // RL7
    end else if (evt_i.ack_done) begin
      ackreq_r <= 1'b0;                                                        // RL7 RL17
    end
  end

  // Arbitration lost flag; a new loss wins over the clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      arbl_r <= 1'b0;
    end else if (arb_lost) begin
      arbl_r <= 1'b1;                                                          // RL8
    end else if (ev_clr) begin
      arbl_r <= 1'b0;                                                          // RL9 RL17
    end
  end

  // Response bit and its written marker
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_r    <= 1'b0;
      ack_wr_r <= 1'b0;
    end else begin
      if (wr_en[SMBCS_B_ACK]) begin
        ack_r <= wr_val[SMBCS_B_ACK];                                          // RL10
      end else if (evt_i.byte_sent) begin
        ack_r <= !evt_i.ack_in;                                                // RL10
      end
      if (wr_en[SMBCS_B_ACK]) begin
        ack_wr_r <= 1'b1;
      end else if (evt_i.byte_rcvd || evt_i.addr_rcvd) begin
        ack_wr_r <= 1'b0;                                                      // RL15
      end
    end
  end

  // Bus event flag; hardware set wins over software clear
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      event_r <= 1'b0;
    end else if (ev_set || (wr_en[SMBCS_B_EVENT] && wr_val[SMBCS_B_EVENT])) begin
      event_r <= 1'b1;                                                         // RL11 RL13
    end else if (ev_clr) begin
      event_r <= 1'b0;                                                         // RL12
    end
  end

  // ==========================================================================
  // Outputs to engine, pins and SFR port
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      next_event_o   <= 1'b0;
      scl_hold_oen_o <= 1'b1;
      ack_out_o      <= 1'b0;
    end else begin
      next_event_o   <= ev_clr && !ev_set;                                     // RL13
      scl_hold_oen_o <= !(event_r || ev_set);                                  // RL12
      ack_out_o      <= ack_r && ack_wr_r;                                     // RL10 RL15
    end
  end

  always_comb begin
    ctrl_status_o = {master_r, tx_ind_r, begin_r, halt_r, ackreq_r, arbl_r, ack_r, event_r};
    stop_req_o    = halt_r;
  end

  // Read port
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= SMBCS_RST_VAL;
    end else if (sfr_rd_i && byte_hit(sfr_addr_i, sfr_page_i)) begin
      sfr_rdata_o <= ctrl_status_o;                                            // RL14
    end else if (sfr_bit_rd_i && bit_hit(sfr_bit_addr_i, sfr_page_i)) begin
      sfr_rdata_o <= {7'h00, ctrl_status_o[sfr_bit_addr_i[2:0]]};              // RL14
    end else begin
      sfr_rdata_o <= 8'h00;
    end
  end

  // ==========================================================================
  // Checks
  a_role_set: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL1
    evt_i.start_gen |=> master_r) else $error("role not set by START");
  a_role_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL1
    (!evt_i.start_gen && (evt_i.stop_gen || arb_lost)) |=> !master_r) else $error("role kept");
  a_tx_clr: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL2
    (!evt_i.start_gen && evt_i.start_det) |=> !tx_ind_r) else $error("tx kept");
  a_begin_sticky: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL16
    (begin_r && !wr_en[SMBCS_B_BEGIN]) |=> begin_r) else $error("begin cleared by hw");
  a_halt_done: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL5
    (evt_i.stop_gen && !arb_i.lost_stop && !wr_en[SMBCS_B_HALT] && !evt_i.stop_det) |=> !stop_req_o)
    else $error("halt kept after STOP");
  a_acknowledge_request_flag_seq: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL7
    evt_i.byte_rcvd |=> ackreq_r) else $error("ack request missing");
  a_arbl_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL9
    (ev_clr && !arb_lost) |=> !arbl_r) else $error("arb lost kept");
  a_ack_read: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL10
    (evt_i.byte_sent && !wr_en[SMBCS_B_ACK]) |=> (ack_r == !$past(evt_i.ack_in))) else $error("ack bit wrong");
  a_nack_default: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL15
    (evt_i.byte_rcvd && !wr_en[SMBCS_B_ACK]) |=> ##1 !ack_out_o) else $error("ACK without write");
  a_stall_scl: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL12
    event_r |=> !scl_hold_oen_o) else $error("clock released while stalled");
  a_event_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL12
    (event_r && !wr_en[SMBCS_B_EVENT]) |=> event_r) else $error("event cleared by hw");
  a_launch: assert property (@(posedge clk_i) disable iff (sys_rst_i) // RL13
    (ev_clr && !ev_set) |=> (next_event_o && !event_r)) else $error("no launch");
  c_start_gen: cover property (@(posedge clk_i) disable iff (sys_rst_i) evt_i.start_gen ##1 master_r);
  c_arb_lost: cover property (@(posedge clk_i) disable iff (sys_rst_i) arb_lost ##1 arbl_r);
  c_rx_ack: cover property (@(posedge clk_i) disable iff (sys_rst_i) ackreq_r ##1 ev_clr ##1 ack_out_o);
endmodule // smbcs_flags
`default_nettype wire

/* hw/smbcs_pkg.sv */
// SMBus control/status flag package: SFR location, bit positions, event carriers.
// Assumes a byte-wide SFR port with bit addressing, and a bus engine on the same clock.
package smbcs_pkg;
  // ==========================================================================
  // SFR location
  localparam logic [7:0] SMBCS_SFR_ADDR  = 8'hC0;   // Control/status register
  localparam logic [7:0] SMBCS_SFR_PAGE  = 8'h00;   // Page holding it
  localparam logic [7:0] SMBCS_RST_VAL   = 8'h00;   // All flags clear
  // ==========================================================================
  // Bit positions
  localparam int SMBCS_B_MASTER = 7;
  localparam int SMBCS_B_TXIND  = 6;
  localparam int SMBCS_B_BEGIN  = 5;
  localparam int SMBCS_B_HALT   = 4;
  localparam int SMBCS_B_ACKREQ = 3;
  localparam int SMBCS_B_ARBL   = 2;
  localparam int SMBCS_B_ACK    = 1;
  localparam int SMBCS_B_EVENT  = 0;
  // ==========================================================================
  // Bus engine reports (one-cycle pulses except the levels noted)
  typedef struct packed {
    logic start_gen;      // START or repeated START generated
    logic stop_gen;       // Pending STOP generated
    logic start_det;      // START seen on the bus
    logic rep_start_det;  // Repeated START seen while a transfer runs
    logic addr_rcvd;      // START plus address byte received
    logic stop_det;       // STOP seen on the bus
    logic byte_sent;      // Byte sent and acknowledge received
    logic byte_rcvd;      // Byte received
    logic ack_done;       // Acknowledge cycle finished
    logic ack_in;         // Sampled acknowledge level, valid with byte_sent
    logic frame_begin;    // A byte frame is about to start
    logic data_wr;        // Data register written by software
    logic slave_addr;     // Level: addressed as a slave
  } smbcs_evt_type;
  typedef struct packed {
    logic gen_stop_rs;    // Level: generating STOP or repeated START
    logic send_one;       // Level: driving a one on data
    logic ack_bit;        // Level: current bit is an acknowledge bit
    logic lost_stop;      // Pulse: arbitration lost to a detected STOP
  } smbcs_arb_type;
endpackage

/* tb/smbcs_bus_model.sv */
// Two-wire bus model for the far side: other controllers and targets on pulled-up lines.
// Assumes open-drain wiring; the flag block only stalls the clock line through its enable.
`timescale 1ns/10ps
`default_nettype none
module smbcs_bus_model (
  input  wire logic scl_hold_oen_i, // Low = flag block pulls clock low
  input  wire logic scl_pull_i,     // High = another party pulls clock low
  input  wire logic sda_pull_i,     // High = another party pulls data low
  output logic      scl_o,          // Resolved clock line level
  output logic      sda_o           // Resolved data line level
);
  // ==========================================================================
  // Wired-and lines; a released line returns to its pull-up level
  assign scl_o = scl_hold_oen_i & ~scl_pull_i;
  assign sda_o = ~sda_pull_i;
endmodule // smbcs_bus_model
`default_nettype wire

/* tb/tb_top.sv */
// Bench for the SMBus control/status flags: register tasks, engine pulses, expected values.
// Assumes one 200 MHz clock and a pulled-up bus model on the clock and data pins.
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import smbcs_pkg::*;
;
  // ==========================================================================
  // Stimulus and observed signals
  logic          clk, rst, wr, rd, bwr, brd, bval, sda_low, scl_low, scl_pin, sda_pin;
  logic [7:0]    addr, page, wdata, baddr, rdata, cs;
  logic          start_req, stop_req, ack_out, next_ev, scl_oen;
  smbcs_evt_type evt;
  smbcs_arb_type arb;
  int            mismatches, num_checks;

  smbcs_flags smbcs_flags_i (.clk_i(clk), .sys_rst_i(rst), .sfr_addr_i(addr), .sfr_page_i(page),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_wdata_i(wdata), .sfr_bit_addr_i(baddr), .sfr_bit_wr_i(bwr),
    .sfr_bit_rd_i(brd), .sfr_bit_val_i(bval), .evt_i(evt), .arb_i(arb), .scl_pin_i(scl_pin),
    .sda_pin_i(sda_pin), .sfr_rdata_o(rdata), .ctrl_status_o(cs), .start_req_o(start_req),
    .stop_req_o(stop_req), .ack_out_o(ack_out), .next_event_o(next_ev), .scl_hold_oen_o(scl_oen));
  smbcs_bus_model smbcs_bus_model_i (.scl_hold_oen_i(scl_oen), .scl_pull_i(scl_low), .sda_pull_i(sda_low),
    .scl_o(scl_pin), .sda_o(sda_pin));

  // ==========================================================================
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // Compare, verdict and access tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr_byte(input logic [7:0] d);
    @(posedge clk);
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    #1;
  endtask
  task automatic wr_bit(input logic [2:0] idx, input logic v);
    @(posedge clk);
    baddr <= SMBCS_SFR_ADDR + {5'h00, idx};
    bval  <= v;
    bwr   <= 1'b1;
    @(posedge clk);
    bwr   <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic bit_mode, input logic [2:0] idx, input logic [7:0] exp);
    @(posedge clk);
    baddr <= SMBCS_SFR_ADDR + {5'h00, idx};
    brd   <= bit_mode;
    rd    <= ~bit_mode;
    @(posedge clk);
    brd   <= 1'b0;
    rd    <= 1'b0;
    #1;
    chk("rdata", rdata, exp);
  endtask
  task automatic ev(input smbcs_evt_type e);
    @(posedge clk);
    evt <= e;
    @(posedge clk);
    evt <= '0;
    #1;
  endtask

  // ==========================================================================
  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    {rst, wr, rd, bwr, brd, bval, sda_low, scl_low} = 8'h80;
    {addr, page, wdata, baddr} = {SMBCS_SFR_ADDR, SMBCS_SFR_PAGE, 16'h0000};
    evt = '0;
    arb = '0;
    mismatches = 0;
    num_checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(1'b0, 3'h0, SMBCS_RST_VAL);
    chk("scl_oen", {7'h00, scl_oen}, 8'h01);
    // Byte write of all ones: read-only bits and halt outside controller role stay clear
    wr_byte(8'hFF);
    chk("cs", cs, 8'h23);
    chk("start_req", {7'h00, start_req}, 8'h01);
    @(posedge clk);
    #1;
    chk("scl_oen", {7'h00, scl_oen}, 8'h00);
    wr_byte(8'h00);
    chk("next_ev", {7'h00, next_ev}, 8'h01);
    chk("cs", cs, 8'h00);
    // Wrong page, unmapped address and read-only bits are all ignored
    @(posedge clk);
    page <= 8'h01;
    wr_byte(8'h21);
    @(posedge clk);
    page <= SMBCS_SFR_PAGE;
    addr <= 8'hC1;
    wr_byte(8'h21);
    @(posedge clk);
    addr <= SMBCS_SFR_ADDR;
    wr_byte(8'hCC);
    chk("cs", cs, 8'h00);
    // Controller start, then a pending stop
    wr_bit(3'h5, 1'b1);
    ev('{start_gen: 1'b1, default: 1'b0});
    chk("cs", cs, 8'hE1);
    chk("start_req", {7'h00, start_req}, 8'h00);
    wr_bit(3'h4, 1'b1);
    chk("stop_req", {7'h00, stop_req}, 8'h01);
    ev('{stop_gen: 1'b1, default: 1'b0});
    chk("cs", cs & 8'h90, 8'h00);
    wr_byte(8'h00);
    // Unwanted repeated start loses arbitration
    ev('{start_gen: 1'b1, default: 1'b0});
    wr_bit(3'h0, 1'b0);
    ev('{rep_start_det: 1'b1, default: 1'b0});
    chk("cs", cs & 8'hC5, 8'h05);
    wr_bit(3'h0, 1'b0);
    chk("cs", cs & 8'h05, 8'h00);
    // Data line pulled low while sending a one
    ev('{start_gen: 1'b1, default: 1'b0});
    wr_bit(3'h0, 1'b0);
    @(posedge clk);
    arb.send_one <= 1'b1;
    sda_low      <= 1'b1;
    for (int i = 0; i < 10 && cs[SMBCS_B_ARBL] !== 1'b1; i++) @(posedge clk);
    #1;
    chk("cs", cs & 8'hC5, 8'h05);
    @(posedge clk);
    arb.send_one <= 1'b0;
    sda_low      <= 1'b0;
    wr_bit(3'h0, 1'b0);
    // Received byte: acknowledge request and outgoing response
    wr_bit(3'h1, 1'b1);
    ev('{byte_rcvd: 1'b1, default: 1'b0});
    chk("cs", cs, 8'h0B);
    @(posedge clk);
    #1;
    chk("ack_out", {7'h00, ack_out}, 8'h00);
    wr_bit(3'h1, 1'b1);
    @(posedge clk);
    #1;
    chk("ack_out", {7'h00, ack_out}, 8'h01);
    ev('{ack_done: 1'b1, default: 1'b0});
    chk("cs", cs & 8'h08, 8'h00);
    wr_bit(3'h0, 1'b0);
    // Sent byte: response bit mirrors the incoming acknowledge
    ev('{byte_sent: 1'b1, ack_in: 1'b1, default: 1'b0});
    chk("cs", cs & 8'h03, 8'h01);
    wr_bit(3'h0, 1'b0);
    ev('{byte_sent: 1'b1, ack_in: 1'b0, default: 1'b0});
    chk("cs", cs & 8'h03, 8'h03);
    wr_bit(3'h0, 1'b0);
    // Target side: stop while addressed, then start plus address
    ev('{stop_det: 1'b1, slave_addr: 1'b1, default: 1'b0});
    chk("cs", cs & 8'h11, 8'h11);
    ev('{addr_rcvd: 1'b1, default: 1'b0});
    chk("cs", cs & 8'h29, 8'h29);
    rd_chk(1'b1, 3'h5, 8'h01);
    wr_bit(3'h0, 1'b0);
    chk("cs", cs & 8'h21, 8'h20);
    // Data written before a frame makes it a transmit frame; no write makes it a receive frame
    ev('{data_wr: 1'b1, default: 1'b0});
    ev('{frame_begin: 1'b1, default: 1'b0});
    chk("cs", cs & 8'h40, 8'h40);
    ev('{frame_begin: 1'b1, default: 1'b0});
    chk("cs", cs & 8'h40, 8'h00);
    ev('{data_wr: 1'b1, frame_begin: 1'b1, default: 1'b0});
    chk("cs", cs & 8'h40, 8'h40);
    ev('{start_det: 1'b1, default: 1'b0});
    chk("cs", cs & 8'h40, 8'h00);
    // Data low during an acknowledge bit is no loss
    @(posedge clk);
    arb     <= '{send_one: 1'b1, ack_bit: 1'b1, default: 1'b0};
    sda_low <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("cs", cs & 8'h05, 8'h00);
    @(posedge clk);
    arb     <= '0;
    sda_low <= 1'b0;
    // Clock held low by another party while a STOP is being made
    ev('{start_gen: 1'b1, default: 1'b0});
    wr_bit(3'h0, 1'b0);
    repeat (4) @(posedge clk);
    arb.gen_stop_rs <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk("cs", cs & 8'h85, 8'h80);
    @(posedge clk);
    scl_low <= 1'b1;
    for (int i = 0; i < 10 && cs[SMBCS_B_ARBL] !== 1'b1; i++) @(posedge clk);
    #1;
    chk("cs", cs & 8'hC5, 8'h05);
    @(posedge clk);
    arb.gen_stop_rs <= 1'b0;
    scl_low         <= 1'b0;
    wr_bit(3'h0, 1'b0);
    // Arbitration lost to a detected STOP
    wr_bit(3'h4, 1'b0);
    @(posedge clk);
    arb.lost_stop <= 1'b1;
    @(posedge clk);
    arb.lost_stop <= 1'b0;
    #1;
    chk("cs", cs & 8'h15, 8'h15);
    // Reset in mid-run, then a first write on the next edge
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("cs", cs, SMBCS_RST_VAL);
    chk("scl_oen", {7'h00, scl_oen}, 8'h01);
    wr_bit(3'h0, 1'b1);
    chk("cs", cs, 8'h01);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
